// file: logic/admrm_top.sv
// ADC mode control and two result-monitoring channels behind an AHB-Lite slave.
// Assumes one AHB-Lite master, word transfers, and a converter core that pulses
// RESULT_VALID for one cycle per completed slot.
//
// How it works
// R1: Bits 11-10 choose resolution: 00 ten-bit, 01 twelve-bit, others reserved.
// R2: Stop bit 8 halts converter when set; software keeps it clear while converting.
// R3: Software writes power mode 100, bit 6 one, other reserved bits zero.
// R4: Monitor interrupt raised once a channel's comparison result becomes settled; here only while that channel's mask bit is set.
// R5: Decision count N in bits 11-8 needs N+1 matching comparisons.
// R6: Two channels, each with own enable, slot select and decision count.
// R7: Enable bit 7 turns monitoring on; clearing it zeroes the count.
// R8: Bits 31-12 and 6-5 of monitor setup read zero; fields reset zero.
// R9: Condition bit 0 matches greater-or-equal, 1 matches less-or-equal.
// R10: Four-bit select picks result slot 0 to 11 by codes 0000-1011.
// R11: Each completed conversion of the selected slot compares and counts matches.
// R12: Counter reaching count setting plus one settles, interrupts, and restarts; here the interrupt needs the channel's mask bit set.
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "admrm_defs.svh"

module admrm_top
  import admrm_pkg::*;
#(
  parameter int DATA_W = 12
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              RESULT_VALID,
  input  wire logic [3:0]        RESULT_SLOT,
  input  wire logic [DATA_W-1:0] RESULT_DATA,
  output logic      [1:0]        CONV_RESOLUTION,
  output logic                   CONV_RES_VALID,
  output logic                   CONV_STOP,
  output logic      [2:0]        CONV_POWER_MODE,
  output logic                   MONITOR_INTERRUPT
);

  admrm_top_s  st_reg;
  admrm_top_s  st_next;
  logic        addr_take;
  logic        done_ok;
  logic        settled0;
  logic        settled1;
  logic [4:0]  count0;
  logic [4:0]  count1;
  logic [1:0]  events;
  logic [1:0]  clear_bits;
  logic [31:0] rd_mux;
  logic [31:0] wdata;

  // ==========================================================================
  // Result qualification
  // A halted converter produces nothing valid, so stray pulses are dropped.
  assign done_ok = RESULT_VALID && !st_reg.stop;  // R2

  // ==========================================================================
  // Monitoring channels
  admrm_monitor #(
    .DATA_W (DATA_W)
  ) u_mon0 (
    .clk       (CLK),
    .nrst      (NRST),
    .enable    (st_reg.setup0[`ADMRM_EN_BIT]),
    .cond_le   (st_reg.setup0[`ADMRM_COND_BIT]),
    .sel       (st_reg.setup0[`ADMRM_SEL_HI:`ADMRM_SEL_LO]),
    .count_cfg (st_reg.setup0[`ADMRM_CNT_HI:`ADMRM_CNT_LO]),
    .cmp_value (st_reg.cmpval0[DATA_W-1:0]),
    .done      (done_ok),
    .done_slot (RESULT_SLOT),
    .done_data (RESULT_DATA),
    .settled   (settled0),
    .count     (count0)
  );  // R6

  admrm_monitor #(
    .DATA_W (DATA_W)
  ) u_mon1 (
    .clk       (CLK),
    .nrst      (NRST),
    .enable    (st_reg.setup1[`ADMRM_EN_BIT]),
    .cond_le   (st_reg.setup1[`ADMRM_COND_BIT]),
    .sel       (st_reg.setup1[`ADMRM_SEL_HI:`ADMRM_SEL_LO]),
    .count_cfg (st_reg.setup1[`ADMRM_CNT_HI:`ADMRM_CNT_LO]),
    .cmp_value (st_reg.cmpval1[DATA_W-1:0]),
    .done      (done_ok),
    .done_slot (RESULT_SLOT),
    .done_data (RESULT_DATA),
    .settled   (settled1),
    .count     (count1)
  );  // R6

  assign events = {settled1, settled0};

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (st_reg.addr)
      `ADMRM_OFS_MODE3:      rd_mux = {16'h0000, st_reg.mode3};
      `ADMRM_OFS_SETUP0:     rd_mux = {20'h00000, st_reg.setup0};  // R8
      `ADMRM_OFS_SETUP1:     rd_mux = {20'h00000, st_reg.setup1};  // R8
      `ADMRM_OFS_CMPVAL0:    rd_mux = {20'h00000, st_reg.cmpval0};
      `ADMRM_OFS_CMPVAL1:    rd_mux = {20'h00000, st_reg.cmpval1};
      `ADMRM_OFS_IRQ_STATUS: rd_mux = {30'h00000000, st_reg.status};
      `ADMRM_OFS_IRQ_MASK:   rd_mux = {30'h00000000, st_reg.mask};
      `ADMRM_OFS_COUNTS:     rd_mux = {19'h00000, count1, 3'h0, count0};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next    = st_reg;
    addr_take  = HSEL && HTRANS[1] && HREADY;
    wdata      = HWDATA;
    clear_bits = 2'h0;

    // Data phase of a write lands one cycle after its address phase
    if (st_reg.bus == ADMRM_BUS_WRITE) begin
      case (st_reg.addr)
        `ADMRM_OFS_MODE3: begin
          st_next.mode3 = wdata[15:0];  // R3
        end
        `ADMRM_OFS_SETUP0: begin
          st_next.setup0 = wdata[11:0] & `ADMRM_SETUP_WMASK;  // R8
        end
        `ADMRM_OFS_SETUP1: begin
          st_next.setup1 = wdata[11:0] & `ADMRM_SETUP_WMASK;  // R8
        end
        `ADMRM_OFS_CMPVAL0: begin
          st_next.cmpval0 = wdata[11:0];
        end
        `ADMRM_OFS_CMPVAL1: begin
          st_next.cmpval1 = wdata[11:0];
        end
        `ADMRM_OFS_IRQ_STATUS: begin
          clear_bits = wdata[1:0];
        end
        `ADMRM_OFS_IRQ_MASK: begin
          st_next.mask = wdata[1:0];
        end
        default: begin
          st_next.mask = st_reg.mask;
        end
      endcase
    end

    // Reads wait one cycle so a write just before is visible
    case (st_reg.bus)
      ADMRM_BUS_IDLE, ADMRM_BUS_WRITE: begin
        st_next.hreadyout = 1'b1;
        if (addr_take) begin
          st_next.addr = {HADDR[7:2], 2'b00};
          if (HWRITE) begin
            st_next.bus = ADMRM_BUS_WRITE;
          end else begin
            st_next.bus       = ADMRM_BUS_READ;
            st_next.hreadyout = 1'b0;
          end
        end else begin
          st_next.bus = ADMRM_BUS_IDLE;
        end
      end
      ADMRM_BUS_READ: begin
        st_next.hrdata    = rd_mux;
        st_next.hreadyout = 1'b1;
        st_next.bus       = ADMRM_BUS_IDLE;
      end
      default: begin
        st_next.bus       = ADMRM_BUS_IDLE;
        st_next.hreadyout = 1'b1;
      end
    endcase

    // Sticky events: a new event beats a same-cycle clear
    st_next.status = (st_reg.status & ~clear_bits) | events;  // R4 R12
    st_next.irq    = |(st_next.status & st_next.mask);  // R4

    // Converter controls follow the mode register
    st_next.res       = st_next.mode3[`ADMRM_RES_HI:`ADMRM_RES_LO];  // R1
    st_next.res_valid = (st_next.res == `ADMRM_RES_10BIT)
                     || (st_next.res == `ADMRM_RES_12BIT);  // R1
    st_next.stop      = st_next.mode3[`ADMRM_STOP_BIT];  // R2
    st_next.power_mode_field     = st_next.mode3[`ADMRM_POWER_MODE_FIELD_HI:`ADMRM_POWER_MODE_FIELD_LO];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg           <= '0;
      st_reg.bus       <= ADMRM_BUS_IDLE;
      st_reg.hreadyout <= 1'b1;
      st_reg.mode3     <= `ADMRM_MODE3_RESET;
      st_reg.setup0    <= `ADMRM_SETUP_RESET;  // R8
      st_reg.setup1    <= `ADMRM_SETUP_RESET;  // R8
      st_reg.cmpval0   <= `ADMRM_CMPVAL_RESET;
      st_reg.cmpval1   <= `ADMRM_CMPVAL_RESET;
      st_reg.status    <= `ADMRM_IRQ_RESET;
      st_reg.mask      <= `ADMRM_IRQ_RESET;
      st_reg.res       <= `ADMRM_RES_12BIT;
      st_reg.res_valid <= 1'b1;
      st_reg.stop      <= 1'b1;
      st_reg.power_mode_field     <= 3'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign HRDATA            = st_reg.hrdata;
  assign HREADYOUT         = st_reg.hreadyout;
  assign HRESP             = 1'b0;
  assign CONV_RESOLUTION   = st_reg.res;
  assign CONV_RES_VALID    = st_reg.res_valid;
  assign CONV_STOP         = st_reg.stop;
  assign CONV_POWER_MODE   = st_reg.power_mode_field;
  assign MONITOR_INTERRUPT = st_reg.irq;

endmodule

// file: logic/admrm_defs.svh
// Register offsets, field positions, reset values and counts of the ADC mode and monitor block.
// Assumes the includer places the register window on a word-aligned AHB-Lite slot.
`ifndef ADMRM_DEFS_SVH
`define ADMRM_DEFS_SVH

// ==========================================================================
// Byte offsets
`define ADMRM_OFS_MODE3       8'h00
`define ADMRM_OFS_SETUP0      8'h04
`define ADMRM_OFS_SETUP1      8'h08
`define ADMRM_OFS_CMPVAL0     8'h0C
`define ADMRM_OFS_CMPVAL1     8'h10
`define ADMRM_OFS_IRQ_STATUS  8'h14
`define ADMRM_OFS_IRQ_MASK    8'h18
`define ADMRM_OFS_COUNTS      8'h1C

// ==========================================================================
// Converter mode three fields
`define ADMRM_MODE3_RESET     16'h0558
`define ADMRM_RES_HI          11
`define ADMRM_RES_LO          10
`define ADMRM_STOP_BIT        8
`define ADMRM_POWER_MODE_FIELD_HI        5
`define ADMRM_POWER_MODE_FIELD_LO        3
`define ADMRM_RES_10BIT       2'h0
`define ADMRM_RES_12BIT       2'h1

// ==========================================================================
// Monitor setup fields
`define ADMRM_SETUP_RESET     12'h000
`define ADMRM_SETUP_WMASK     12'hF9F
`define ADMRM_CNT_HI          11
`define ADMRM_CNT_LO          8
`define ADMRM_EN_BIT          7
`define ADMRM_COND_BIT        4
`define ADMRM_SEL_HI          3
`define ADMRM_SEL_LO          0
`define ADMRM_LAST_SLOT       4'hB

// ==========================================================================
// Misc
`define ADMRM_CMPVAL_RESET    12'h000
`define ADMRM_IRQ_RESET       2'h0

`endif

// file: logic/admrm_pkg.sv
// Types shared by the ADC mode and monitor block.
// Assumes admrm_defs.svh supplies the numeric constants other than the bus state codes set here.
package admrm_pkg;

  // ==========================================================================
  // Bus phase tracker
  typedef enum logic [2:0] {
    ADMRM_BUS_IDLE  = 3'b001,
    ADMRM_BUS_WRITE = 3'b010,
    ADMRM_BUS_READ  = 3'b100
  } admrm_bus_e;

  // ==========================================================================
  // Top-level state
  typedef struct packed {
    admrm_bus_e  bus;
    logic [7:0]  addr;
    logic [15:0] mode3;
    logic [11:0] setup0;
    logic [11:0] setup1;
    logic [11:0] cmpval0;
    logic [11:0] cmpval1;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        irq;
    logic [1:0]  res;
    logic        res_valid;
    logic        stop;
    logic [2:0]  power_mode_field;
  } admrm_top_s;

  // ==========================================================================
  // Monitor channel state
  typedef struct packed {
    logic [4:0] count;
    logic       settled;
  } admrm_mon_s;

endpackage

// file: logic/admrm_monitor.sv
// One result-monitoring channel: compare, count matches, flag a settled result.
// Assumes done pulses last one cycle and carry the completed slot and its data.
`timescale 1ns/100ps
`include "admrm_defs.svh"

module admrm_monitor
  import admrm_pkg::*;
#(
  parameter int DATA_W = 12
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              enable,
  input  wire logic              cond_le,
  input  wire logic [3:0]        sel,
  input  wire logic [3:0]        count_cfg,
  input  wire logic [DATA_W-1:0] cmp_value,
  input  wire logic              done,
  input  wire logic [3:0]        done_slot,
  input  wire logic [DATA_W-1:0] done_data,
  output logic                   settled,
  output logic [4:0]             count
);

  admrm_mon_s st_reg;
  admrm_mon_s st_next;
  logic       hit;
  logic       match;

  // ==========================================================================
  // Compare and count
  always_comb begin
    st_next         = st_reg;
    st_next.settled = 1'b0;
    hit             = done && (done_slot == sel) && (sel <= `ADMRM_LAST_SLOT);  // R10 R11
    match           = cond_le ? (done_data <= cmp_value) : (done_data >= cmp_value);  // R9
    if (!enable) begin
      st_next.count = 5'h00;  // R7
    end else if (hit && match) begin
      if (st_reg.count == {1'b0, count_cfg}) begin
        st_next.count   = 5'h00;  // R12
        st_next.settled = 1'b1;  // R4 R5
      end else begin
        st_next.count = st_reg.count + 5'h01;  // R11
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign settled = st_reg.settled;
  assign count   = st_reg.count;

endmodule

// file: sim/admrm_chk.sv
// Port checker of the ADC mode and monitor block.
// Bound into admrm_top; watches its ports only.
`timescale 1ns/100ps
module admrm_chk (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        RESULT_VALID,
  input wire logic [1:0]  CONV_RESOLUTION,
  input wire logic        CONV_RES_VALID,
  input wire logic        CONV_STOP,
  input wire logic        MONITOR_INTERRUPT
);
  // ====
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence rd_ans_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  bus_okay_a: assert property (HRESP == 1'b0)
    else $error("error response seen");
  rd_wait_a: assert property ((HSEL && HTRANS[1] && HREADY && !HWRITE) |=> rd_ans_s)
    else $error("read wait state wrong");
  wr_nowait_a: assert property ((HSEL && HTRANS[1] && HREADY && HWRITE) |=> HREADYOUT)
    else $error("write stalled");
  rdata_hold_a: assert property (!$stable(HRDATA) |-> $past(HREADYOUT) == 1'b0)
    else $error("read data moved outside a read");
  res_code_a: assert property (CONV_RES_VALID == !CONV_RESOLUTION[1])
    else $error("resolution valid flag wrong");
  mode_hold_a: assert property (!$stable({CONV_STOP, CONV_RESOLUTION}) |->
    $past(HSEL, 2) || $past(HSEL, 3))
    else $error("mode output moved without a write");
  irq_cause_a: assert property ($rose(MONITOR_INTERRUPT) |->
    $past(RESULT_VALID, 2) || $past(HSEL, 2))
    else $error("interrupt rose without cause");
  irq_sticky_a: assert property ($fell(MONITOR_INTERRUPT) |-> $past(HSEL, 2))
    else $error("interrupt fell without a write");
endmodule

bind admrm_top admrm_chk u_admrm_chk (.*);

// file: sim/admrm_core_model.sv
// Model of the converter core that reports completed results.
// Assumes the bench asks for at most one result per cycle.
`timescale 1ns/100ps
module admrm_core_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [3:0]  req_slot,
  input  wire logic [11:0] req_data,
  output logic             valid,
  output logic      [3:0]  slot,
  output logic      [11:0] data
);
  initial {valid, slot, data} = '0;
  // Idle lines toggle each cycle between the inverse and the last result
  always @(posedge clk) begin
    valid <= req;
    slot  <= req ? req_slot : ~slot;
    data  <= req ? req_data : ~data;
  end
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the ADC mode and monitor block.
// Drives AHB-Lite and a core model; reads are checked through a queue.
`timescale 1ns/100ps
`include "admrm_defs.svh"
module tb_top;
  logic        CLK, NRST, HSEL, HWRITE, go, rd_pend = 1'b0;
  logic        HREADYOUT, HRESP, RESULT_VALID, CONV_RES_VALID, CONV_STOP;
  logic        MONITOR_INTERRUPT;
  logic [1:0]  HTRANS, CONV_RESOLUTION;
  logic [2:0]  HSIZE, CONV_POWER_MODE;
  logic [3:0]  gslot, RESULT_SLOT;
  logic [11:0] gdata, RESULT_DATA;
  logic [31:0] HADDR, HWDATA, HRDATA, rnd;
  logic [31:0] expq[$];
  int          n_errors = 0, samples_checked = 0;

  admrm_top u_admrm_top (.*, .HREADY(HREADYOUT));
  admrm_core_model u_admrm_core_model (.clk(CLK), .req(go), .req_slot(gslot),
    .req_data(gdata), .valid(RESULT_VALID), .slot(RESULT_SLOT), .data(RESULT_DATA));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // ====
  // Helpers
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic addr(logic [7:0] a, logic w);
    HSEL   <= 1'b1;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr(a, 1'b1);
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    addr(a, 1'b0);
    expq.push_back(e);
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic pulse(logic [3:0] s, logic [11:0] d);
    go    <= 1'b1;
    gslot <= s;
    gdata <= d;
    @(posedge CLK);
    go    <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic irq(logic e);
    repeat (4) @(posedge CLK);
    chk("irq", {31'h0, e}, {31'h0, MONITOR_INTERRUPT});
  endtask
  // Channel zero needs n+1 matches; foreign slots and misses in between
  task automatic settle(logic [3:0] n, logic c, logic [3:0] s);
    logic [11:0] v, m;
    wr(`ADMRM_OFS_SETUP0, {20'h0, n, 3'h4, c, s});
    for (int i = 0; i <= n; i++) begin
      irq(1'b0);
      rnd = lfsr(rnd);
      v = (i == 0) ? 12'h100 : {3'h0, !c, rnd[7:0]};
      m = {2'h0, c, 1'b0, rnd[7:0]};
      pulse(s + 4'h1, v);
      pulse(s, m);
      pulse(s, v);
    end
  endtask

  // Read results appear when a read data phase completes
  always @(posedge CLK) begin
    if (rd_pend && HREADYOUT) chk("read", expq.pop_front(), HRDATA);
    if (HREADYOUT) rd_pend = HSEL && HTRANS[1] && !HWRITE;
  end

  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    wrap_up();
  end

  // ====
  // Scenarios
  initial begin
    {NRST, HSEL, HWRITE, go, HTRANS, gslot, gdata, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
    rnd   = 32'h7696942F;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    chk("stop", 32'h1, {31'h0, CONV_STOP});
    rd(`ADMRM_OFS_MODE3, 32'h0558);
    rd(`ADMRM_OFS_SETUP0, 32'h0);
    rd(8'h20, 32'h0);
    wr(`ADMRM_OFS_SETUP0, 32'hFFFFFFFF);
    rd(`ADMRM_OFS_SETUP0, 32'hF9F);
    for (int r = 3; r >= 0; r--) begin
      wr(`ADMRM_OFS_MODE3, {20'h0, r[1:0], 10'h060});
      rd(`ADMRM_OFS_MODE3, {20'h0, r[1:0], 10'h060});
      chk("res", {30'h0, r[1:0]}, {30'h0, CONV_RESOLUTION});
      chk("res_ok", {31'h0, (r < 2)}, {31'h0, CONV_RES_VALID});
      chk("power_mode_field", 32'h4, {29'h0, CONV_POWER_MODE});
    end
    chk("stop", 32'h0, {31'h0, CONV_STOP});
    wr(`ADMRM_OFS_CMPVAL0, 32'h100);
    settle(4'h0, 1'b0, 4'h0);
    irq(1'b0);
    rd(`ADMRM_OFS_IRQ_STATUS, 32'h1);
    wr(`ADMRM_OFS_IRQ_MASK, 32'h3);
    irq(1'b1);
    wr(`ADMRM_OFS_IRQ_STATUS, 32'h1);
    irq(1'b0);
    settle(4'h1, 1'b1, 4'hB);
    irq(1'b1);
    rd(`ADMRM_OFS_COUNTS, 32'h0);
    wr(`ADMRM_OFS_IRQ_STATUS, 32'h1);
    settle(4'hF, 1'b0, 4'h5);
    irq(1'b1);
    wr(`ADMRM_OFS_IRQ_STATUS, 32'h1);
    wr(`ADMRM_OFS_SETUP0, 32'h0380);
    pulse(4'h0, 12'h200);
    pulse(4'h0, 12'h200);
    rd(`ADMRM_OFS_COUNTS, 32'h2);
    wr(`ADMRM_OFS_SETUP0, 32'h0300);
    rd(`ADMRM_OFS_COUNTS, 32'h0);
    wr(`ADMRM_OFS_SETUP0, 32'h0080);
    wr(`ADMRM_OFS_MODE3, 32'h0160);
    pulse(4'h0, 12'hFFF);
    rd(`ADMRM_OFS_IRQ_STATUS, 32'h0);
    wr(`ADMRM_OFS_MODE3, 32'h0060);
    wr(`ADMRM_OFS_CMPVAL1, 32'h800);
    wr(`ADMRM_OFS_SETUP1, 32'h0083);
    pulse(4'h3, 12'h7FF);
    pulse(4'h3, 12'hFFF);
    rd(`ADMRM_OFS_IRQ_STATUS, 32'h2);
    wr(`ADMRM_OFS_IRQ_STATUS, 32'h3);
    irq(1'b0);
    wrap_up();
  end
endmodule
